// ==== wdr_pkg.sv ====
// constants, types and helpers for the watchdog reset unit
// Contract
// - a reset-mode time-out emits a reset pulse of exactly one clock
// - the delay timer starts on the falling edge of that pulse
// - the counter counts ticks of a 128kHz oscillator, not system clocks
// - reaching the selected time-out triggers the action of the active mode
// - a restart zeroes the counter; software restarts before time-out
// - interrupt mode raises an interrupt without reset, usable for wake-up
// - reset mode issues a system reset on expiry
// - combined mode interrupts first, then the next time-out resets
// - the always-on fuse forces reset enable 1 and interrupt enable 0
// - clearing reset enable or changing prescaler needs the timed sequence
// - within four clocks a write with change enable clear is accepted
// - time-out selectable from 16ms to 8s
// - after a watchdog reset the watchdog stays enabled
// - change enable clears itself four clocks after being set
// - reset enable reads set and cannot clear while the reset flag is set
// - time-out flag sets on interrupt time-out; cleared by vector or one
// - prescaler code selects 2048 to 1048576 cycles; codes above 9 reserved
`default_nettype none
package wdr_pkg;
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned OSC_HZ = 128_000;
  localparam int unsigned OSC_DIV = CLK_HZ / OSC_HZ;
  localparam int unsigned TOUT_MIN_MS = 16;
  localparam int unsigned TOUT_MAX_MS = 8000;
  localparam int unsigned CNT_W = 21;
  localparam logic [20:0] BASE_CYCLES = 21'h000800;
  localparam logic [3:0] PRESC_MAX = 4'h9;
  localparam logic [2:0] CE_HOLD = 3'h4;
  localparam int unsigned ADDR_W = 4;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_CAUSE = 4'h4;
  localparam logic [3:0] OFS_RESTART = 4'h8;
  localparam logic [3:0] OFS_ACK = 4'hc;
  localparam int unsigned CAUSE_DOG_BIT = 3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [3:0] PRESC_RST = 4'h0;

  typedef enum logic [1:0] {
    WDR_STOPPED, WDR_INT, WDR_RST, WDR_INTRST
  } wdr_mode_e;

  typedef struct packed {
    logic timeout_flag;
    logic interrupt_enable_bit;
    logic prescaler_select_hi;
    logic change_enable_bit;
    logic reset_enable_bit;
    logic [2:0] prescaler_select_lo;
  } wdr_ctrl_s;

  function automatic logic [20:0] wdr_limit(input logic [3:0] sel);
    logic [3:0] s;
    s = (sel > PRESC_MAX) ? PRESC_MAX : sel;
    return (BASE_CYCLES << s) - 21'h000001;
  endfunction

  function automatic logic wdr_mapped(input logic [3:0] a);
    return (a == OFS_CTRL) || (a == OFS_CAUSE) ||
           (a == OFS_RESTART) || (a == OFS_ACK);
  endfunction
endpackage
`default_nettype wire

// ==== wdr_tick.sv ====
// oscillator-rate tick enable derived from the system clock
`timescale 1ns/10ps
`default_nettype none
module wdr_tick #(
  parameter int unsigned DIV = wdr_pkg::OSC_DIV
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  output logic tick
);
  import wdr_pkg::*;
  logic [15:0] div_q;

  // one pulse per oscillator period
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 16'h0000;
      tick <= 1'b0;
    end else if (div_q == 16'(DIV - 1)) begin
      div_q <= 16'h0000;
      tick <= 1'b1;
    end else begin
      div_q <= div_q + 16'h0001;
      tick <= 1'b0;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_tick_gap;
    tick |=> !tick;
  endproperty
  a_tick_gap: assert property (p_tick_gap) else $error("tick too long");
endmodule // wdr_tick
`default_nettype wire

// ==== wdr_count.sv ====
// watchdog counter with selectable time-out
`timescale 1ns/10ps
`default_nettype none
module wdr_count (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic run,
  input wire logic restart,
  input wire logic [3:0] prescaler_select,
  output logic expire
);
  import wdr_pkg::*;
  logic [20:0] cnt_q;
  logic hit;

  assign hit = tick && run && !restart &&
               (cnt_q == wdr_limit(prescaler_select));

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= 21'h000000;
    end else if (!run || restart || hit) begin
      cnt_q <= 21'h000000;
    end else if (tick) begin
      cnt_q <= cnt_q + 21'h000001;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      expire <= 1'b0;
    end else begin
      expire <= hit;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_expire_at_limit;
    expire |-> $past(cnt_q) == wdr_limit($past(prescaler_select));
  endproperty
  a_expire_at_limit: assert property (p_expire_at_limit)
    else $error("expiry not at limit");
  property p_restart_zero;
    restart |=> cnt_q == 21'h000000;
  endproperty
  a_restart_zero: assert property (p_restart_zero)
    else $error("restart did not zero counter");
endmodule // wdr_count
`default_nettype wire

// ==== wdr_top.sv ====
// watchdog reset unit with axi4-lite register access
`timescale 1ns/10ps
`default_nettype none
module wdr_top #(
  parameter int unsigned OSC_DIV = wdr_pkg::OSC_DIV
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic always_on_fuse,
  input wire logic [wdr_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [wdr_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic dog_irq,
  output logic dog_reset_pulse,
  output logic delay_start
);
  import wdr_pkg::*;

  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0] wdata_q;
  logic wstrb0_q;
  logic aw_hold_q;
  logic w_hold_q;
  logic do_wr;
  logic wr_ctrl;
  logic wr_cause;
  logic wr_restart;
  logic wr_ack;
  wdr_ctrl_s wv;
  logic timeout_flag_q;
  logic ie_q;
  logic re_q;
  logic ce_q;
  logic [2:0] ce_cnt_q;
  logic [3:0] prescaler_select_q;
  logic dog_reset_flag_q;
  logic ce_open;
  logic re_eff;
  wdr_mode_e mode;
  logic tick;
  logic expire;
  logic ev_q;
  logic fire;
  logic set_flag;
  wdr_ctrl_s rd_ctrl;

  // write channels taken independently, write done once both held
  assign do_wr = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign wv = wdr_ctrl_s'(wdata_q);
  assign wr_ctrl = do_wr && wstrb0_q && (awaddr_q == OFS_CTRL);
  assign wr_cause = do_wr && wstrb0_q && (awaddr_q == OFS_CAUSE);
  assign wr_restart = do_wr && (awaddr_q == OFS_RESTART);
  assign wr_ack = do_wr && (awaddr_q == OFS_ACK);
  assign ce_open = wr_ctrl && wv.change_enable_bit && wv.reset_enable_bit;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      aw_hold_q <= 1'b0;
      s_axi_awready <= 1'b1;
      awaddr_q <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_hold_q <= 1'b1;
      s_axi_awready <= 1'b0;
      awaddr_q <= s_axi_awaddr;
    end else if (do_wr) begin
      aw_hold_q <= 1'b0;
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      w_hold_q <= 1'b0;
      s_axi_wready <= 1'b1;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_hold_q <= 1'b1;
      s_axi_wready <= 1'b0;
      wdata_q <= s_axi_wdata[7:0];
      wstrb0_q <= s_axi_wstrb[0];
    end else if (do_wr) begin
      w_hold_q <= 1'b0;
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wdr_mapped(awaddr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // read side
  always_comb begin
    rd_ctrl.timeout_flag = timeout_flag_q;
    rd_ctrl.interrupt_enable_bit = ie_q;
    rd_ctrl.prescaler_select_hi = prescaler_select_q[3];
    rd_ctrl.change_enable_bit = ce_q;
    rd_ctrl.reset_enable_bit = re_eff;
    rd_ctrl.prescaler_select_lo = prescaler_select_q[2:0];
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= wdr_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      if (s_axi_araddr == OFS_CTRL) begin
        s_axi_rdata <= {24'h000000, rd_ctrl};
      end else if (s_axi_araddr == OFS_CAUSE) begin
        s_axi_rdata <= 32'(dog_reset_flag_q) << CAUSE_DOG_BIT;
      end else begin
        s_axi_rdata <= 32'h00000000;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // mode decode
  assign re_eff = re_q || dog_reset_flag_q;
  always_comb begin
    if (always_on_fuse) begin
      mode = WDR_RST;
    end else begin
      unique case ({re_eff, ie_q})
        2'b00: mode = WDR_STOPPED;
        2'b01: mode = WDR_INT;
        2'b10: mode = WDR_RST;
        2'b11: mode = WDR_INTRST;
      endcase
    end
  end

  // change enable window
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ce_q <= 1'b0;
      ce_cnt_q <= 3'h0;
    end else if (ce_open) begin
      ce_q <= 1'b1;
      ce_cnt_q <= CE_HOLD;
    end else if (ce_q) begin
      ce_q <= (ce_cnt_q != 3'h1);
      ce_cnt_q <= ce_cnt_q - 3'h1;
    end
  end

  // reset enable
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      re_q <= 1'b0;
    end else if (always_on_fuse) begin
      re_q <= 1'b1;
    end else if (ce_open) begin
      re_q <= 1'b1;
    end else if (wr_ctrl && ce_q && !wv.change_enable_bit) begin
      re_q <= wv.reset_enable_bit || dog_reset_flag_q;
    end else if (wr_ctrl) begin
      re_q <= re_q || wv.reset_enable_bit || dog_reset_flag_q;
    end else begin
      re_q <= re_q || dog_reset_flag_q;
    end
  end

  // prescaler
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prescaler_select_q <= PRESC_RST;
    end else if (wr_ctrl && ce_q && !wv.change_enable_bit) begin
      prescaler_select_q <= {wv.prescaler_select_hi,
                             wv.prescaler_select_lo};
    end
  end

  // interrupt enable
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ie_q <= 1'b0;
    end else if (always_on_fuse) begin
      ie_q <= 1'b0;
    end else if (wr_ctrl) begin
      ie_q <= wv.interrupt_enable_bit;
    end else if (wr_ack && mode == WDR_INTRST) begin
      ie_q <= 1'b0;
    end
  end

  wdr_tick #(
    .DIV(OSC_DIV)
  ) u_tick (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tick(tick)
  );

  wdr_count u_count (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tick(tick),
    .run(mode != WDR_STOPPED),
    .restart(wr_restart || fire),
    .prescaler_select(prescaler_select_q),
    .expire(expire)
  );

  // time-out action
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      ev_q <= 1'b0;
    end else begin
      ev_q <= expire;
    end
  end

  assign fire = ev_q && (mode == WDR_RST ||
                (mode == WDR_INTRST && timeout_flag_q));
  assign set_flag = ev_q && (mode == WDR_INT ||
                    (mode == WDR_INTRST && !timeout_flag_q));

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      timeout_flag_q <= 1'b0;
    end else if (set_flag) begin
      timeout_flag_q <= 1'b1;
    end else if (wr_ack || (wr_ctrl && wv.timeout_flag)) begin
      timeout_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dog_reset_flag_q <= 1'b0;
    end else if (fire) begin
      dog_reset_flag_q <= 1'b1;
    end else if (wr_cause && !wdata_q[CAUSE_DOG_BIT]) begin
      dog_reset_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dog_reset_pulse <= 1'b0;
      delay_start <= 1'b0;
      dog_irq <= 1'b0;
    end else begin
      dog_reset_pulse <= fire;
      delay_start <= dog_reset_pulse && !fire;
      dog_irq <= timeout_flag_q && ie_q;
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  property p_pulse_one;
    dog_reset_pulse |=> !dog_reset_pulse;
  endproperty
  a_pulse_one: assert property (p_pulse_one)
    else $error("reset pulse longer than one clock");
  property p_delay_fall;
    $fell(dog_reset_pulse) |-> delay_start;
  endproperty
  a_delay_fall: assert property (p_delay_fall)
    else $error("delay not started on pulse fall");
  property p_ce_four;
    $rose(ce_q) |-> ce_q [*4] ##1 (!ce_q || $past(ce_open));
  endproperty
  a_ce_four: assert property (p_ce_four)
    else $error("change enable not cleared after four clocks");
  property p_re_held;
    dog_reset_flag_q |=> re_q;
  endproperty
  a_re_held: assert property (p_re_held)
    else $error("reset enable cleared while reset flag set");
  property p_fuse;
    always_on_fuse |=> re_q && !ie_q;
  endproperty
  a_fuse: assert property (p_fuse)
    else $error("fuse did not force reset mode");
  property p_int_mode;
    ev_q && mode == WDR_INT |=> timeout_flag_q && !dog_reset_pulse ##1 dog_irq;
  endproperty
  a_int_mode: assert property (p_int_mode)
    else $error("interrupt mode misbehaved");
  property p_rst_mode;
    ev_q && mode == WDR_RST |=> dog_reset_pulse && dog_reset_flag_q;
  endproperty
  a_rst_mode: assert property (p_rst_mode)
    else $error("reset mode gave no reset");
  property p_comb_first;
    ev_q && mode == WDR_INTRST && !timeout_flag_q
      |=> timeout_flag_q && !dog_reset_pulse;
  endproperty
  a_comb_first: assert property (p_comb_first)
    else $error("combined mode first time-out wrong");
  property p_presc_locked;
    wr_ctrl && !ce_q |=> $stable(prescaler_select_q);
  endproperty
  a_presc_locked: assert property (p_presc_locked)
    else $error("prescaler changed outside window");
endmodule // wdr_top
`default_nettype wire

// ==== wdr_rst_model.sv ====
// system reset logic model that receives the watchdog reset request
`timescale 1ns/10ps
`default_nettype none
module wdr_rst_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic dog_reset_pulse,
  input wire logic delay_start,
  output logic [7:0] resets,
  output logic [7:0] errs
);
  logic pulse_q;
  logic wait_q;
  logic fall;
  logic bad;
  assign fall = pulse_q && !dog_reset_pulse;
  // pulse longer than one clock, or delay start not right after the fall
  assign bad = (dog_reset_pulse && pulse_q) ||
               (delay_start && !fall && !wait_q) ||
               (wait_q && !delay_start);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pulse_q <= 1'b0;
      wait_q <= 1'b0;
      resets <= 8'h00;
      errs <= 8'h00;
    end else begin
      pulse_q <= dog_reset_pulse;
      wait_q <= fall && !delay_start;
      if (dog_reset_pulse && !pulse_q) begin
        resets <= resets + 8'h01;
      end
      if (bad) begin
        errs <= errs + 8'h01;
      end
    end
  end
endmodule // wdr_rst_model
`default_nettype wire

// ==== wdr_top_tb.sv ====
// self-checking testbench for the watchdog reset unit
`timescale 1ns/10ps
`default_nettype none
module wdr_top_tb;
  import wdr_pkg::*;
  localparam int DIV = 2;
  localparam int T0 = 2048 * DIV;
  localparam int T1 = 4096 * DIV;
  logic clk_sys, rst_n, always_on_fuse;
  logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready, dog_irq, dog_reset_pulse, delay_start;
  logic [7:0] resets, errs, base;
  int fail_count, check_count, n;

  wdr_top #(.OSC_DIV(DIV)) u_wdr_top (.clk_sys(clk_sys), .rst_n(rst_n),
    .always_on_fuse(always_on_fuse), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .dog_irq(dog_irq), .dog_reset_pulse(dog_reset_pulse),
    .delay_start(delay_start));
  wdr_rst_model u_wdr_rst_model (.clk_sys(clk_sys), .rst_n(rst_n),
    .dog_reset_pulse(dog_reset_pulse), .delay_start(delay_start),
    .resets(resets), .errs(errs));

  always #2 clk_sys = ~clk_sys;

  task automatic summarize();
    if (fail_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] got,
                     input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rdr(input logic [3:0] a);
    @(posedge clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
    rdr(a);
    chk("register", rd, e);
  endtask

  task automatic wait_irq(input int lim);
    n = 0;
    while (dog_irq !== 1'b1 && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
  endtask

  task automatic wait_rst(input int lim);
    logic [7:0] c0;
    c0 = resets;
    n = 0;
    while (resets === c0 && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
  endtask

  function automatic logic near(input int v, input int t);
    return (v >= t - 8) && (v <= t + 16);
  endfunction

  initial begin
    #300000;
    fail_count++;
    summarize();
  end

  initial begin
    clk_sys = 1'b0;
    rst_n = 1'b0;
    always_on_fuse = 1'b0;
    s_axi_awaddr = 4'h0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h00000000;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = 4'h0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    fail_count = 0;
    check_count = 0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    // reset values and unmapped place
    rdchk(OFS_CTRL, 32'h00000000);
    rdchk(OFS_CAUSE, 32'h00000000);
    rdchk(4'h2, 32'h00000000);
    chk("read resp", rsp, RESP_SLVERR);
    wr(4'h2, 8'hff);
    chk("write resp", rsp, RESP_SLVERR);
    // interrupt mode
    wr(OFS_CTRL, 8'h40);
    wait_irq(T0 + 50);
    chk("irq time", near(n, T0), 1'b1);
    chk("no reset", resets, 8'h00);
    rdchk(OFS_CTRL, 32'h000000c0);
    wr(OFS_ACK, 8'h00);
    rdchk(OFS_CTRL, 32'h00000040);
    chk("irq off", dog_irq, 1'b0);
    wait_irq(T0 + 50);
    wr(OFS_CTRL, 8'hc0);
    rdchk(OFS_CTRL, 32'h00000040);
    wr(OFS_CTRL, 8'h00);
    // reset mode with restart
    wr(OFS_CTRL, 8'h08);
    repeat (3000) @(posedge clk_sys);
    wr(OFS_RESTART, 8'h00);
    repeat (3000) @(posedge clk_sys);
    chk("restart", resets, 8'h00);
    wait_rst(T0);
    chk("rst time", near(n, T0 - 3000), 1'b1);
    rdchk(OFS_CAUSE, 32'h00000008);
    wait_rst(T0 + 50);
    chk("again", near(n, T0), 1'b1);
    // reset enable held while the dog flag stands
    wr(OFS_CTRL, 8'h18);
    wr(OFS_CTRL, 8'h00);
    rdchk(OFS_CTRL, 32'h00000008);
    // write without byte lane 0 leaves the cause flag alone
    s_axi_wstrb <= 4'h0;
    wr(OFS_CAUSE, 8'h00);
    s_axi_wstrb <= 4'hf;
    rdchk(OFS_CAUSE, 32'h00000008);
    wr(OFS_CAUSE, 8'h00);
    rdchk(OFS_CAUSE, 32'h00000000);
    // late second write is ignored
    wr(OFS_CTRL, 8'h18);
    repeat (8) @(posedge clk_sys);
    wr(OFS_CTRL, 8'h00);
    rdchk(OFS_CTRL, 32'h00000008);
    // proper timed sequence loads prescaler 1
    wr(OFS_CTRL, 8'h18);
    wr(OFS_CTRL, 8'h09);
    rdchk(OFS_CTRL, 32'h00000009);
    wr(OFS_CTRL, 8'h0d);
    rdchk(OFS_CTRL, 32'h00000009);
    wr(OFS_RESTART, 8'h00);
    wait_rst(T1 + 50);
    chk("presc 1", near(n, T1), 1'b1);
    // combined mode
    wr(OFS_CAUSE, 8'h00);
    wr(OFS_CTRL, 8'h49);
    wr(OFS_RESTART, 8'h00);
    base = resets;
    wait_irq(T1 + 50);
    chk("int first", near(n, T1), 1'b1);
    chk("int first rst", resets, base);
    wait_rst(T1 + 50);
    chk("then reset", near(n, T1), 1'b1);
    chk("pulse shape", errs, 8'h00);
    // vector in combined mode drops to plain reset mode
    wr(OFS_ACK, 8'h00);
    rdchk(OFS_CTRL, 32'h00000009);
    // always-on fuse
    @(posedge clk_sys);
    always_on_fuse <= 1'b1;
    wr(OFS_CTRL, 8'h40);
    rdr(OFS_CTRL);
    chk("fuse", rd & 32'h00000048, 32'h00000008);
    summarize();
  end
endmodule // wdr_top_tb
`default_nettype wire
